// file: fsr_pkg.sv
// Purpose: shared constants and types for the flash status and read logic
// Assumes: single-bit serial framing, most significant bit first
// Notes:   status byte positions, opcodes and frame bit counts live here
`default_nettype none

package fsr_pkg;

    // system clock rate used to turn times into cycle counts
    localparam int unsigned CLK_MHZ = 125;

    // opcodes handled by this block
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_DATA    = 8'h03;
    localparam logic [7:0] OP_WRITE_OFF    = 8'h04;
    localparam logic [7:0] OP_READ_STATUS  = 8'h05;
    localparam logic [7:0] OP_WRITE_ON     = 8'h06;

    // serial bit counts at the end of each frame part
    localparam logic [5:0] CNT_CMD   = 6'h08;
    localparam logic [5:0] CNT_WRITE_STATUS_CMD  = 6'h10;
    localparam logic [5:0] CNT_ADDR  = 6'h20;
    localparam logic [5:0] CNT_MAX   = 6'h3F;
    localparam logic [5:0] CNT_ONE   = 6'h01;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // status byte field positions
    localparam int ST_LOCK  = 7;
    localparam int ST_PROTECT_PIN_DISABLE = 6;
    localparam int ST_BP_HI = 5;
    localparam int ST_BP_LO = 2;
    localparam int ST_WEL   = 1;
    localparam int ST_BUSY  = 0;

    // array operation kinds requested by the array command decoder
    localparam logic [1:0] KIND_PAGE  = 2'h0;
    localparam logic [1:0] KIND_SECT  = 2'h1;
    localparam logic [1:0] KIND_BLOCK = 2'h2;
    localparam logic [1:0] KIND_CHIP  = 2'h3;

    // reset values and one-step increments
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [23:0] ADDR_ZERO = 24'h000000;
    localparam logic [23:0] ADDR_ONE  = 24'h000001;
    localparam logic [23:0] TIME_ZERO = 24'h000000;
    localparam logic [23:0] TIME_ONE  = 24'h000001;
    localparam logic [3:0]  BP_ZERO   = 4'h0;

    // non-volatile part of the status register
    typedef struct packed {
        logic       seal;
        logic       lock;
        logic       protect_pin_disable;
        logic [3:0] bp;
    } fsr_nv_t;

    localparam fsr_nv_t NV_ZERO = '{seal: 1'b0, lock: 1'b0, protect_pin_disable: 1'b0, bp: 4'h0};

    // status write cycle sequencer
    typedef enum logic [1:0] {
        WS_IDLE  = 2'b01,
        WS_WRITE = 2'b10
    } fsr_wstate_t;

endpackage

`default_nettype wire

// file: fsr_status_read.sv
// Purpose: status register, status read/write and single-bit data read of a serial flash
// Assumes: serial clock runs only inside frames; array read data is valid for ARRAY_ADDR_O on the serial clock
// Notes:   serial side on SCK_I, status state on CLOCK_I; frame results cross when select rises
`timescale 1ns/1ps
`default_nettype none

module fsr_status_read #(
    parameter int unsigned T_W_US = 10
) (
    // system clock, reset and enable
    input  wire logic                CLOCK_I,
    input  wire logic                RESET_N_I,
    input  wire logic                CE_I,
    // serial link pins
    input  wire logic                SCK_I,
    input  wire logic                SELECT_N_I,
    input  wire logic                SERIAL_IN_I,
    output logic                     SERIAL_OUT_O,
    output logic                     SERIAL_OUT_OE_N_O,
    input  wire logic                PROTECT_PIN_N_I,
    // mode levels from the rest of the device (system clock)
    input  wire logic                QUAD_MODE_I,
    input  wire logic                OTP_MODE_I,
    // non-volatile storage
    input  wire fsr_pkg::fsr_nv_t    NV_INIT_I,
    output fsr_pkg::fsr_nv_t         NV_DATA_O,
    output logic                     NV_WR_O,
    // array read port (serial clock)
    output logic [23:0]              ARRAY_ADDR_O,
    input  wire logic [7:0]          ARRAY_DATA_I,
    // array program and erase permission (system clock)
    input  wire logic                ARRAY_REQ_I,
    input  wire logic [1:0]          ARRAY_KIND_I,
    input  wire logic                ARRAY_PROT_HIT_I,
    input  wire logic                ARRAY_OTP_HIT_I,
    output logic                     ARRAY_GRANT_O,
    input  wire logic                ARRAY_BUSY_I,
    input  wire logic                ARRAY_DONE_I,
    // status view
    output logic [7:0]               STATUS_O,
    output logic                     HW_PROTECT_O
);

    localparam int unsigned TW_CYCLES = (T_W_US * fsr_pkg::CLK_MHZ < 1) ? 1 : T_W_US * fsr_pkg::CLK_MHZ;
    localparam logic [23:0] TW_LAST   = 24'(TW_CYCLES - 1);

    // assembles the status byte from its parts
    function automatic logic [7:0] status_byte(input fsr_pkg::fsr_nv_t nv, input logic otp,
                                               input logic write_latch, input logic busy);
        logic [7:0] s;
        s = fsr_pkg::BYTE_ZERO;
        s[fsr_pkg::ST_LOCK]                    = otp ? nv.seal : nv.lock;
        s[fsr_pkg::ST_PROTECT_PIN_DISABLE]                   = nv.protect_pin_disable;
        s[fsr_pkg::ST_BP_HI:fsr_pkg::ST_BP_LO] = nv.bp;
        s[fsr_pkg::ST_WEL]                     = write_latch;
        s[fsr_pkg::ST_BUSY]                    = busy;
        return s;
    endfunction

    // serial side, rising edge
    logic              in_frame_q;
    logic [5:0]        cnt_q, cnt_d;
    logic [7:0]        shift_q, shift_d;
    logic [7:0]        cmd_q, cmd_d;
    logic [7:0]        wdata_q, wdata_d;
    logic [23:0]       addr_q, addr_d;
    logic [2:0]        dbit_q, dbit_d;
    logic              rd_ok_q, rd_ok_d;
    logic              req_s1_q, req_s2_q;
    logic              ack_q, ack_d;
    logic [7:0]        copy_q, copy_d;
    logic              quad_s1_q, quad_s2_q;

    // serial side, falling edge
    logic [2:0]        obit_q, obit_d;
    logic [7:0]        obyte_q, obyte_d;
    logic              so_q, so_d;
    logic              oe_n_q, oe_n_d;
    logic              st_act, rd_act;

    // system side
    logic              cs_s1_q, cs_s2_q, cs_s3_q;
    logic              wp_s1_q, wp_s2_q;
    logic              ack_s1_q, ack_s2_q;
    fsr_pkg::fsr_wstate_t state_q, state_d;
    logic [23:0]       timer_q, timer_d;
    logic              wel_q, wel_d;
    fsr_pkg::fsr_nv_t  nv_q, nv_d;
    fsr_pkg::fsr_nv_t  pend_q, pend_d;
    logic              loaded_q, loaded_d;
    logic              req_q, req_d;
    logic [7:0]        pub_q, pub_d;
    logic              nv_wr_q, nv_wr_d;
    logic [7:0]        stat_q, stat_d;
    logic              hpm_q, hpm_d;
    logic              busy, hw_protected_mode, frame_end, write_status_cmd_ok, write_status_cmd_done, wel_set, wel_clr, op_allowed;

    // frame marker; select high clears it so a stale count is never reused
    always_ff @(posedge SCK_I or posedge SELECT_N_I) begin
        if (SELECT_N_I) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    // rising edge: sample serial_in, count bits, catch command, data and address
    always_comb begin
        shift_d = {shift_q[6:0], SERIAL_IN_I};
        if (!in_frame_q) begin
            cnt_d = fsr_pkg::CNT_ONE;
        end else if (cnt_q == fsr_pkg::CNT_MAX) begin
            cnt_d = cnt_q;
        end else begin
            cnt_d = cnt_q + fsr_pkg::CNT_ONE;
        end
        cmd_d   = (cnt_d == fsr_pkg::CNT_CMD)  ? shift_d : cmd_q;
        wdata_d = (cnt_d == fsr_pkg::CNT_WRITE_STATUS_CMD) ? shift_d : wdata_q;
        addr_d  = addr_q;
        dbit_d  = fsr_pkg::BIT_FIRST;
        if (in_frame_q && cnt_q >= fsr_pkg::CNT_CMD && cnt_q < fsr_pkg::CNT_ADDR) begin
            addr_d = {addr_q[22:0], SERIAL_IN_I};
        end else if (in_frame_q && cnt_q >= fsr_pkg::CNT_ADDR) begin
            dbit_d = dbit_q + 3'h1;
            if (dbit_q == fsr_pkg::BIT_LAST) begin
                addr_d = addr_q + fsr_pkg::ADDR_ONE;
            end
        end
        // busy or quad mode at the end of the address refuses the read
        rd_ok_d = (cnt_d == fsr_pkg::CNT_ADDR) ? (!copy_q[fsr_pkg::ST_BUSY] && !quad_s2_q) : rd_ok_q;
        // status word handshake: the system side holds pub_q until acknowledged
        ack_d  = ack_q;
        copy_d = copy_q;
        if (req_s2_q != ack_q) begin
            copy_d = pub_q;
            ack_d  = req_s2_q;
        end
    end

    // rising edge registers; persistent across frames so the system side can read them
    always_ff @(posedge SCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cnt_q     <= 6'h00;
            shift_q   <= fsr_pkg::BYTE_ZERO;
            cmd_q     <= fsr_pkg::BYTE_ZERO;
            wdata_q   <= fsr_pkg::BYTE_ZERO;
            addr_q    <= fsr_pkg::ADDR_ZERO;
            dbit_q    <= fsr_pkg::BIT_FIRST;
            rd_ok_q   <= 1'b0;
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            ack_q     <= 1'b0;
            copy_q    <= fsr_pkg::BYTE_ZERO;
            quad_s1_q <= 1'b0;
            quad_s2_q <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            shift_q   <= shift_d;
            cmd_q     <= cmd_d;
            wdata_q   <= wdata_d;
            addr_q    <= addr_d;
            dbit_q    <= dbit_d;
            rd_ok_q   <= rd_ok_d;
            req_s1_q  <= req_q;
            req_s2_q  <= req_s1_q;
            ack_q     <= ack_d;
            copy_q    <= copy_d;
            quad_s1_q <= QUAD_MODE_I;
            quad_s2_q <= quad_s1_q;
        end
    end

    // falling edge: shift status or array bytes out, msb first
    always_comb begin
        st_act  = in_frame_q && !quad_s2_q && cmd_q == fsr_pkg::OP_READ_STATUS
                  && cnt_q >= fsr_pkg::CNT_CMD;
        rd_act  = in_frame_q && cmd_q == fsr_pkg::OP_READ_DATA
                  && cnt_q >= fsr_pkg::CNT_ADDR && rd_ok_q;
        obit_d  = fsr_pkg::BIT_FIRST;
        obyte_d = obyte_q;
        so_d    = 1'b0;
        oe_n_d  = 1'b1;
        if (st_act || rd_act) begin
            oe_n_d = 1'b0;
            obit_d = obit_q + 3'h1;
            if (obit_q == fsr_pkg::BIT_FIRST) begin
                // fresh status copy per byte so busy is seen to fall while polling
                obyte_d = st_act ? copy_q : ARRAY_DATA_I;
                so_d    = obyte_d[7];
                obyte_d = {obyte_d[6:0], 1'b0};
            end else begin
                so_d    = obyte_q[7];
                obyte_d = {obyte_q[6:0], 1'b0};
            end
        end
    end

    // falling edge registers; select high releases the pin at once
    always_ff @(negedge SCK_I or posedge SELECT_N_I) begin
        if (SELECT_N_I) begin
            obit_q  <= fsr_pkg::BIT_FIRST;
            obyte_q <= fsr_pkg::BYTE_ZERO;
            so_q    <= 1'b0;
            oe_n_q  <= 1'b1;
        end else begin
            obit_q  <= obit_d;
            obyte_q <= obyte_d;
            so_q    <= so_d;
            oe_n_q  <= oe_n_d;
        end
    end

    // system side decode of a finished frame and of the protection state
    always_comb begin
        busy       = (state_q == fsr_pkg::WS_WRITE) || ARRAY_BUSY_I;
        hw_protected_mode        = nv_q.lock && !wp_s2_q && !nv_q.protect_pin_disable;
        frame_end  = cs_s2_q && !cs_s3_q && !QUAD_MODE_I;
        // exact bit count: select must rise right after the eighth data bit
        write_status_cmd_ok    = frame_end && cmd_q == fsr_pkg::OP_WRITE_STATUS
                     && cnt_q == fsr_pkg::CNT_WRITE_STATUS_CMD
                     && wel_q && !busy && !hw_protected_mode && loaded_q;
        write_status_cmd_done  = state_q == fsr_pkg::WS_WRITE && timer_q == TW_LAST;
        wel_set    = frame_end && cmd_q == fsr_pkg::OP_WRITE_ON && cnt_q == fsr_pkg::CNT_CMD;
        wel_clr    = (frame_end && cmd_q == fsr_pkg::OP_WRITE_OFF && cnt_q == fsr_pkg::CNT_CMD)
                     || write_status_cmd_done || ARRAY_DONE_I;
        op_allowed = (ARRAY_KIND_I == fsr_pkg::KIND_CHIP) ? (nv_q.bp == fsr_pkg::BP_ZERO)
                                                          : !ARRAY_PROT_HIT_I;
        op_allowed = op_allowed && !(ARRAY_OTP_HIT_I && nv_q.seal);
    end

    // system side next state
    always_comb begin
        state_d  = state_q;
        timer_d  = timer_q;
        nv_d     = nv_q;
        pend_d   = pend_q;
        nv_wr_d  = 1'b0;
        loaded_d = 1'b1;
        if (!loaded_q) begin
            nv_d = NV_INIT_I;
        end
        // a set arriving with a clear wins
        wel_d = wel_set ? 1'b1 : (wel_clr ? 1'b0 : wel_q);
        case (state_q)
            fsr_pkg::WS_IDLE: begin
                timer_d = fsr_pkg::TIME_ZERO;
                if (write_status_cmd_ok) begin
                    state_d = fsr_pkg::WS_WRITE;
                    pend_d  = nv_q;
                    if (OTP_MODE_I) begin
                        pend_d.seal = 1'b1;
                    end else begin
                        // latch and busy positions of the data byte are dropped
                        pend_d.lock  = wdata_q[fsr_pkg::ST_LOCK];
                        pend_d.protect_pin_disable = wdata_q[fsr_pkg::ST_PROTECT_PIN_DISABLE];
                        pend_d.bp    = wdata_q[fsr_pkg::ST_BP_HI:fsr_pkg::ST_BP_LO];
                    end
                end
            end
            fsr_pkg::WS_WRITE: begin
                timer_d = timer_q + fsr_pkg::TIME_ONE;
                if (write_status_cmd_done) begin
                    state_d   = fsr_pkg::WS_IDLE;
                    nv_d      = pend_q;
                    nv_d.seal = pend_q.seal || nv_q.seal;
                    nv_wr_d   = 1'b1;
                end
            end
            default: begin
                state_d = fsr_pkg::WS_IDLE;
            end
        endcase
        stat_d = status_byte(nv_q, OTP_MODE_I, wel_q, busy);
        hpm_d  = hw_protected_mode;
        // publish a changed status word once the serial side has taken the last one
        req_d = req_q;
        pub_d = pub_q;
        if (req_q == ack_s2_q && pub_q != stat_q) begin
            pub_d = stat_q;
            req_d = !req_q;
        end
    end

    // system side registers, synchronous reset; otherwise frozen while the enable is low
    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            wp_s1_q  <= 1'b1;
            wp_s2_q  <= 1'b1;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            state_q  <= fsr_pkg::WS_IDLE;
            timer_q  <= fsr_pkg::TIME_ZERO;
            wel_q    <= 1'b0;
            nv_q     <= fsr_pkg::NV_ZERO;
            pend_q   <= fsr_pkg::NV_ZERO;
            loaded_q <= 1'b0;
            req_q    <= 1'b0;
            pub_q    <= fsr_pkg::BYTE_ZERO;
            nv_wr_q  <= 1'b0;
            stat_q   <= fsr_pkg::BYTE_ZERO;
            hpm_q    <= 1'b0;
        end else if (CE_I) begin
            cs_s1_q  <= SELECT_N_I;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            wp_s1_q  <= PROTECT_PIN_N_I;
            wp_s2_q  <= wp_s1_q;
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            state_q  <= state_d;
            timer_q  <= timer_d;
            wel_q    <= wel_d;
            nv_q     <= nv_d;
            pend_q   <= pend_d;
            loaded_q <= loaded_d;
            req_q    <= req_d;
            pub_q    <= pub_d;
            nv_wr_q  <= nv_wr_d;
            stat_q   <= stat_d;
            hpm_q    <= hpm_d;
        end
    end

    // outputs
    assign SERIAL_OUT_O      = so_q;
    assign SERIAL_OUT_OE_N_O = oe_n_q;
    assign ARRAY_ADDR_O      = addr_q;
    assign NV_DATA_O         = nv_q;
    assign NV_WR_O           = nv_wr_q;
    assign STATUS_O          = stat_q;
    assign HW_PROTECT_O      = hpm_q;
    // grant is a handshake answer; refused whenever the latch is clear or a cycle runs
    assign ARRAY_GRANT_O     = ARRAY_REQ_I && loaded_q && wel_q && !busy && op_allowed;

endmodule

`default_nettype wire

// file: fsr_status_read_assertions.sv
// Purpose: port-level checks for the flash status and read block
// Assumes: CE_I stays high while checks run
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none

module fsr_status_read_assertions #(
    parameter int unsigned T_W_US = 10
) (
    // clock and reset
    input wire logic             CLOCK_I,
    input wire logic             RESET_N_I,
    // serial side
    input wire logic             SELECT_N_I,
    input wire logic             SERIAL_OUT_OE_N_O,
    // array permission
    input wire logic             ARRAY_REQ_I,
    input wire logic [1:0]       ARRAY_KIND_I,
    input wire logic             ARRAY_PROT_HIT_I,
    input wire logic             ARRAY_GRANT_O,
    input wire logic             ARRAY_BUSY_I,
    // status and storage
    input wire fsr_pkg::fsr_nv_t NV_DATA_O,
    input wire logic             NV_WR_O,
    input wire logic [7:0]       STATUS_O,
    input wire logic             HW_PROTECT_O
);
    localparam int unsigned BUSY_CYC = T_W_US * fsr_pkg::CLK_MHZ;
    logic [15:0] busy_len_q;
    logic [15:0] busy_len_d;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);

    // length of the busy stretch; 16 bits cover the longest write time
    always_comb begin
        busy_len_d = STATUS_O[fsr_pkg::ST_BUSY] ? busy_len_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge CLOCK_I) begin
        busy_len_q <= RESET_N_I ? busy_len_d : 16'h0000;
    end

    // busy, grant and protection relations
    chk_busy_shown: assert property ($rose(ARRAY_BUSY_I) |-> ##[1:2] STATUS_O[fsr_pkg::ST_BUSY])
        else $error("array busy not shown");
    chk_grant_cause: assert property (ARRAY_GRANT_O |-> ARRAY_REQ_I && !ARRAY_BUSY_I)
        else $error("grant without request or while busy");
    chk_chip_guard: assert property (ARRAY_GRANT_O && ARRAY_KIND_I == fsr_pkg::KIND_CHIP
        |-> NV_DATA_O.bp == fsr_pkg::BP_ZERO) else $error("chip erase granted under protection");
    chk_region_guard: assert property (ARRAY_GRANT_O && ARRAY_PROT_HIT_I
        |-> NV_DATA_O.bp == fsr_pkg::BP_ZERO) else $error("protected region granted");
    // status write cycle end, seal, protection and output release
    chk_done_clears: assert property (NV_WR_O && !ARRAY_BUSY_I |-> ##[1:3] STATUS_O[1:0] == 2'b00)
        else $error("busy or latch left set after write");
    chk_write_length: assert property (NV_WR_O |-> busy_len_q + 16'h0004 >= 16'(BUSY_CYC))
        else $error("status write cycle too short");
    chk_seal_sticky: assert property (!$fell(NV_DATA_O.seal))
        else $error("seal bit cleared");
    chk_hw_cause: assert property (HW_PROTECT_O && $stable(NV_DATA_O)
        |-> NV_DATA_O.lock && !NV_DATA_O.protect_pin_disable) else $error("hw protect without cause");
    chk_oe_release: assert property (SELECT_N_I && $past(SELECT_N_I) |-> SERIAL_OUT_OE_N_O)
        else $error("output driven while deselected");
endmodule

bind fsr_status_read fsr_status_read_assertions #(.T_W_US(T_W_US)) i_chk (
    .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .SELECT_N_I(SELECT_N_I),
    .SERIAL_OUT_OE_N_O(SERIAL_OUT_OE_N_O), .ARRAY_REQ_I(ARRAY_REQ_I),
    .ARRAY_KIND_I(ARRAY_KIND_I), .ARRAY_PROT_HIT_I(ARRAY_PROT_HIT_I),
    .ARRAY_GRANT_O(ARRAY_GRANT_O), .ARRAY_BUSY_I(ARRAY_BUSY_I), .NV_DATA_O(NV_DATA_O),
    .NV_WR_O(NV_WR_O), .STATUS_O(STATUS_O), .HW_PROTECT_O(HW_PROTECT_O)
);
`default_nettype wire

// file: fsr_host_model.sv
// Purpose: host serial controller, mode 0, 32 ns serial clock
// Assumes: caller keeps frames apart by several system clocks
// Notes:   a released data line reads as the inverse of its last value
`timescale 1ns/1ps
`default_nettype none

module fsr_host_model (
    // serial pins toward the device
    output logic      sck_o,
    output logic      select_n_o,
    output logic      serial_in_o,
    input  wire logic serial_out_i,
    input  wire logic serial_out_oe_n_i
);
    logic last_q;

    // idle: clock low and still, deselected
    initial begin
        sck_o = 1'b0;
        select_n_o = 1'b0;
        serial_in_o = 1'b0;
        last_q = 1'b0;
        // a clean rising select once the design waits, so its frame marker starts known
        #1 select_n_o = 1'b1;
    end

    // one frame of nb bits, msb first; replies sampled on rising clock
    task automatic frame(input int nb, input logic [63:0] tx, output logic [63:0] rx, output logic drove);
        rx = '0;
        drove = 1'b0;
        #5.3 select_n_o = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            serial_in_o = tx[i];
            #16 sck_o = 1'b1;
            if (!serial_out_oe_n_i) last_q = serial_out_i;
            drove = drove | !serial_out_oe_n_i;
            rx = {rx[62:0], serial_out_oe_n_i ? ~last_q : serial_out_i};
            #16 sck_o = 1'b0;
        end
        #16 select_n_o = 1'b1;
        serial_in_o = ~serial_in_o;
        #60;
    endtask
endmodule
`default_nettype wire

// file: tb_flash_status_and_read_logic.sv
// Purpose: self-checking bench for the flash status and read block
// Assumes: short status write time so busy lasts 375 clocks
// Notes:   array bytes are their address folded with 5Ah
`timescale 1ns/1ps
`default_nettype none

module tb_flash_status_and_read_logic;
    logic             clock, reset_n, ce, sck, select_n, si, so, so_oe_n, prot_n, quad, otp;
    logic             nv_wr, arr_req, arr_prot, arr_otp, arr_grant, arr_busy, arr_done, hw_prot;
    logic [1:0]       arr_kind;
    logic [7:0]       arr_data, status;
    logic [23:0]      arr_addr;
    fsr_pkg::fsr_nv_t nv_init, nv_data;
    logic [63:0]      rx;
    logic             drove;
    int               mismatches, n_tests;

    fsr_status_read #(.T_W_US(3)) i_dut (
        .CLOCK_I(clock), .RESET_N_I(reset_n), .CE_I(ce), .SCK_I(sck), .SELECT_N_I(select_n),
        .SERIAL_IN_I(si), .SERIAL_OUT_O(so), .SERIAL_OUT_OE_N_O(so_oe_n), .PROTECT_PIN_N_I(prot_n),
        .QUAD_MODE_I(quad), .OTP_MODE_I(otp), .NV_INIT_I(nv_init), .NV_DATA_O(nv_data),
        .NV_WR_O(nv_wr), .ARRAY_ADDR_O(arr_addr), .ARRAY_DATA_I(arr_data), .ARRAY_REQ_I(arr_req),
        .ARRAY_KIND_I(arr_kind), .ARRAY_PROT_HIT_I(arr_prot), .ARRAY_OTP_HIT_I(arr_otp),
        .ARRAY_GRANT_O(arr_grant), .ARRAY_BUSY_I(arr_busy), .ARRAY_DONE_I(arr_done),
        .STATUS_O(status), .HW_PROTECT_O(hw_prot));
    fsr_host_model i_host (.sck_o(sck), .select_n_o(select_n), .serial_in_o(si),
        .serial_out_i(so), .serial_out_oe_n_i(so_oe_n));

    // array content model
    assign arr_data = arr_addr[7:0] ^ 8'h5A;

    // system clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // a frame, then room for the result to cross into the system clock
    task automatic cmd(input int nb, input logic [63:0] tx);
        i_host.frame(nb, tx, rx, drove);
        repeat (8) @(posedge clock);
    endtask

    task automatic rd_status(input logic [7:0] e);
        cmd(24, 64'h050000);
        check("status_read", rx[15:0], {e, e});
    endtask

    // polls busy like a careful host, bounded
    task automatic wait_idle;
        int n;
        n = 0;
        while (status[fsr_pkg::ST_BUSY] !== 1'b0 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        check("busy_wait", 16'(n < 1000), 16'h0001);
    endtask

    task automatic req(input logic [1:0] k, input logic p, input logic o, input logic e);
        @(posedge clock);
        arr_req <= 1'b1;
        arr_kind <= k;
        arr_prot <= p;
        arr_otp <= o;
        @(negedge clock);
        check("grant", 16'(arr_grant), 16'(e));
        @(posedge clock) arr_req <= 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard, well beyond the expected run
    initial begin
        #150000;
        mismatches++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        // reset falls after time zero so the asynchronous serial-side clear is seen
        reset_n = 1'b1;
        #1;
        {reset_n, quad, otp, arr_req, arr_kind, arr_prot, arr_otp, arr_busy, arr_done} = '0;
        {ce, prot_n} = 2'b11;
        nv_init = 7'h03;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (6) @(posedge clock);
        check("status", 16'(status), 16'h000C);
        rd_status(8'h0C);
        cmd(16, 64'h013C);
        check("status", 16'(status), 16'h000C);
        cmd(8, 64'h06);
        check("status", 16'(status), 16'h000E);
        cmd(15, 64'h00FF);
        check("status", 16'(status), 16'h000E);
        cmd(16, 64'h01BF);
        rd_status(8'h0F);
        cmd(48, 64'h0003FFFFFF0000);
        check("read_busy", 16'(drove), 16'h0000);
        wait_idle();
        check("status", 16'(status), 16'h00BC);
        check("nv", 16'(nv_data), 16'h002F);
        @(posedge clock) prot_n <= 1'b0;
        repeat (6) @(posedge clock);
        check("hw", 16'(hw_prot), 16'h0001);
        cmd(8, 64'h06);
        cmd(16, 64'h0100);
        check("status_hi", 16'(status[7:2]), 16'h002F);
        @(posedge clock) prot_n <= 1'b1;
        cmd(8, 64'h06);
        req(fsr_pkg::KIND_CHIP, 1'b0, 1'b0, 1'b0);
        req(fsr_pkg::KIND_PAGE, 1'b1, 1'b0, 1'b0);
        req(fsr_pkg::KIND_SECT, 1'b0, 1'b0, 1'b1);
        @(posedge clock) arr_busy <= 1'b1;
        repeat (3) @(posedge clock);
        check("busy", 16'(status[fsr_pkg::ST_BUSY]), 16'h0001);
        req(fsr_pkg::KIND_BLOCK, 1'b0, 1'b0, 1'b0);
        @(posedge clock) arr_busy <= 1'b0;
        arr_done <= 1'b1;
        @(posedge clock) arr_done <= 1'b0;
        repeat (3) @(posedge clock);
        check("latch_busy", 16'(status[1:0]), 16'h0000);
        req(fsr_pkg::KIND_PAGE, 1'b0, 1'b0, 1'b0);
        cmd(8, 64'h06);
        cmd(16, 64'h01C0);
        wait_idle();
        @(posedge clock) prot_n <= 1'b0;
        repeat (6) @(posedge clock);
        check("hw_off", 16'(hw_prot), 16'h0000);
        cmd(8, 64'h06);
        cmd(16, 64'h0100);
        wait_idle();
        check("status", 16'(status), 16'h0000);
        @(posedge clock) prot_n <= 1'b1;
        cmd(48, 64'h0003FFFFFF0000);
        check("read_wrap", rx[15:0], 16'hA55A);
        cmd(36, 64'h0030000100);
        check("oe_abort", 16'(so_oe_n), 16'h0001);
        check("abort_drove", 16'(drove), 16'h0001);
        rd_status(8'h00);
        @(posedge clock) quad <= 1'b1;
        cmd(48, 64'h0003FFFFFF0000);
        check("read_quad", 16'(drove), 16'h0000);
        @(posedge clock) quad <= 1'b0;
        otp <= 1'b1;
        cmd(8, 64'h06);
        cmd(16, 64'h017C);
        wait_idle();
        check("status", 16'(status), 16'h0080);
        cmd(8, 64'h06);
        req(fsr_pkg::KIND_PAGE, 1'b0, 1'b1, 1'b0);
        check("latch_on", 16'(status), 16'h0082);
        cmd(8, 64'h04);
        check("latch_off", 16'(status), 16'h0080);
        tally_and_finish();
    end
endmodule
`default_nettype wire
